// ---- logic/ump_pkg.sv ----
// Overview of operation
// RULE1 - Stop code F is two; short codes stretch
// RULE2 - Three channel-B mode registers share one address
// RULE3 - Reset or set-pointer command selects mode zero
// RULE4 - Mode zero access moves pointer to one
// RULE5 - Mode one access moves pointer to two
// RULE6 - Mode two access leaves pointer alone
// RULE7 - Channel-B mode zero: no FIFO bit, low three reserved
// RULE8 - Clock select: receiver high nibble, transmitter low
// RULE9 - Receiver codes E/F use pin four
// RULE10 - Transmitter codes E/F use pin three
// RULE11 - Receiver clock is 16x except code F
// RULE12 - Transmitter clock is 16x except code F
// RULE13 - Rate depends on code, extended bits, aux bit
// RULE14 - Code C gives the top rates per mode; with ext2 set, code 6 gives 115200 here, above code C's 38400 or 19200
// RULE15 - Code D selects the counter/timer output
// RULE16 - Rates divide the 3.6864 MHz reference
// RULE17 - Command 0001 returns pointer to mode one
// RULE18 - Divisors reproduce each table rate closely
`default_nettype none

package ump_pkg;

	// Register offsets on the four-bit register port.
	localparam logic [3:0] MODE_A_ADDR   = 4'h0;
	localparam logic [3:0] CSR_A_ADDR    = 4'h1;
	localparam logic [3:0] CMD_A_ADDR    = 4'h2;
	localparam logic [3:0] AUX_ADDR      = 4'h4;
	localparam logic [3:0] STATUS_ADDR   = 4'h5;
	localparam logic [3:0] CHAN_STRIDE   = 4'h8;

	// Reset values of the programmable registers.
	localparam logic [7:0] MODE_RESET    = 8'h00;
	localparam logic [7:0] CSR_RESET     = 8'h00;
	localparam logic [7:0] AUX_RESET     = 8'h00;

	// Readable bits of mode zero per channel; channel B lacks the FIFO size bit.
	localparam logic [7:0] MODE0_MASK_A  = 8'hFF;
	localparam logic [7:0] MODE0_MASK_B  = 8'hF0;

	// Field positions.
	localparam int EXT1_BIT   = 0;
	localparam int EXT2_BIT   = 2;
	localparam int AUX_SET_BIT = 7;
	localparam int CMD_LSB    = 4;

	// Miscellaneous command codes in the command register upper nibble.
	localparam logic [3:0] CMD_PTR_ONE   = 4'h1;
	localparam logic [3:0] CMD_PTR_ZERO  = 4'hB;

	// Clock select codes with special meaning.
	localparam logic [3:0] SEL_TIMER     = 4'hD;
	localparam logic [3:0] SEL_PIN_X16   = 4'hE;
	localparam logic [3:0] SEL_PIN_X1    = 4'hF;

	// Stop length, in sixteenths of a bit.
	localparam logic [5:0] STOP_SHORT_BASE = 6'h09;
	localparam logic [5:0] STOP_LONG_BASE  = 6'h11;
	localparam logic [5:0] STOP_TWO        = 6'h20;
	localparam logic [5:0] STOP_FIVE_EXTRA = 6'h08;
	localparam logic [1:0] CHAR_FIVE       = 2'h0;

	// Reference oscillator and system clock, both in Hz.
	localparam int REF_HZ     = 3686400;
	localparam int CLK_HZ     = 100000000;
	// Phase accumulator step and modulus, reduced by 100 to fit 20 bits.
	localparam logic [19:0] NCO_STEP = 20'(REF_HZ / 100);
	localparam logic [19:0] NCO_MOD  = 20'(CLK_HZ / 100);
	localparam int OVERSAMPLE = 16;

	// Mode register pointer, one-hot.
	typedef enum logic [2:0] {
		PTR_ZERO = 3'b001,
		PTR_ONE  = 3'b010,
		PTR_TWO  = 3'b100
	} ump_ptr_t;

	// Reference ticks per 16x clock for a rate code; zero for codes D to F.
	function automatic logic [12:0] ump_divisor(input logic [3:0] code,
		input logic ext1, input logic ext2, input logic aux);
		logic [12:0] d;
		d = 13'h0000;
		unique case (code)
			4'h0: d = ext1 ? (aux ? 13'd512 : 13'd768) :
				ext2 ? (aux ? 13'd32 : 13'd48) : (aux ? 13'd3072 : 13'd4608);
			4'h1: d = (ext2 && !ext1) ? 13'd262 : 13'd2096;
			4'h2: d = (ext2 && !ext1) ? 13'd214 : 13'd1712;
			4'h3: d = ext1 ? (aux ? 13'd256 : 13'd192) :
				ext2 ? (aux ? 13'd16 : 13'd12) : (aux ? 13'd1536 : 13'd1152);
			4'h4: d = ext1 ? 13'd128 : ext2 ? 13'd8 : 13'd768;
			4'h5: d = ext1 ? 13'd64 : ext2 ? 13'd4 : 13'd384;
			4'h6: d = ext1 ? 13'd32 : ext2 ? 13'd2 : 13'd192;
			4'h7: d = aux ? 13'd115 : 13'd220;
			4'h8: d = ext1 ? 13'd16 : ext2 ? 13'd4 : 13'd96;
			4'h9: d = ext1 ? 13'd8 : 13'd48;
			4'hA: d = (ext2 && !ext1) ? (aux ? 13'd16 : 13'd4) : (aux ? 13'd128 : 13'd32);
			4'hB: d = ext1 ? 13'd4 : 13'd24;
			4'hC: d = ext1 ? (aux ? 13'd2 : 13'd1) : (aux ? 13'd12 : 13'd6);
			default: d = 13'h0000;
		endcase
		return d;
	endfunction

endpackage

`default_nettype wire

// ---- logic/ump_rate_div.sv ----
`default_nettype none

// Divides reference ticks down to one 16x clock pulse per divisor count.
module ump_rate_div #(
	parameter int W = 13
) (
	// Clock and reset.
	input  wire logic         clock_i,
	input  wire logic         nrst_i,
	// Reference tick and divisor.
	input  wire logic         ref_tick_i,
	input  wire logic [W-1:0] divisor_i,
	// Output pulse.
	output logic              tick_o
);

	logic [W-1:0] count;
	logic         wrap;

	// A shrinking divisor must not strand the counter above it, hence the compare.
	assign wrap = ref_tick_i && (count >= divisor_i - W'(1));

	// Count reference ticks and pulse once per full divisor.
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			count  <= '0;
			tick_o <= 1'b0;
		end else begin
			tick_o <= wrap && (divisor_i != '0);
			if (wrap) begin
				count <= '0;
			end else if (ref_tick_i) begin
				count <= count + W'(1);
			end
		end
	end

endmodule

`default_nettype wire

// ---- logic/ump_top.sv ----
// The plain strobed port was decided locally.
`default_nettype none

// Mode pointers, stop length and baud clock selection for two channels.
module ump_top #(
	parameter int DIV_W = 13
) (
	// Clock and reset.
	input  wire logic        clock_i,
	input  wire logic        nrst_i,
	// Register port.
	input  wire logic [3:0]  addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [7:0]  rdata_o,
	// Clock sources.
	input  wire logic        input_pin_three_i,
	input  wire logic        input_pin_four_i,
	input  wire logic        timer_tick_i,
	// Per-channel receiver clocks, index 0 is channel A.
	output logic      [1:0]  rx_sample_tick_o,
	output logic      [1:0]  rx_bit_tick_o,
	output logic      [1:0]  rx_x1_o,
	// Per-channel transmitter clocks.
	output logic      [1:0]  tx_sample_tick_o,
	output logic      [1:0]  tx_bit_tick_o,
	output logic      [1:0]  tx_x1_o,
	// Per-channel stop length in sixteenths of a bit.
	output logic [1:0][5:0]  stop_len_o
);

	// Register state.
	logic [1:0][7:0]         mode_zero;
	logic [1:0][7:0]         mode_one;
	logic [1:0][7:0]         mode_two;
	logic [1:0][7:0]         clock_select;
	logic [1:0][2:0]         pointer;
	logic [7:0]              aux_control_reg;

	// Decode results.
	logic [1:0]              hit_mode;
	logic [1:0]              hit_csr;
	logic [1:0]              hit_cmd;
	logic                    hit_aux;
	logic                    hit_status;
	logic [1:0]              mode_access;
	logic [1:0][2:0]         next_pointer;
	logic [1:0][7:0]         mode_read;
	logic [7:0]              next_rdata;

	// Reference oscillator and pin edges.
	logic [19:0]             phase;
	logic [20:0]             phase_sum;
	logic                    ref_wrap;
	logic                    ref_tick;
	logic                    pin_three_q;
	logic                    pin_four_q;
	logic                    pin_three_edge;
	logic                    pin_four_edge;

	// Aux and extended mode bits, shared by both channels.
	logic                    aux_set;
	logic                    ext1;
	logic                    ext2;

	// Shared register decode; address, bus and status.
	assign hit_aux    = addr_i == ump_pkg::AUX_ADDR;
	assign hit_status = addr_i == ump_pkg::STATUS_ADDR;
	assign aux_set    = aux_control_reg[ump_pkg::AUX_SET_BIT];
	// Channel A mode zero carries the extended rate bits for both channels.
	assign ext1       = mode_zero[0][ump_pkg::EXT1_BIT]; // RULE13
	assign ext2       = mode_zero[0][ump_pkg::EXT2_BIT]; // RULE13

	// Per-channel register file.
	for (genvar c = 0; c < 2; c++) begin : g_chan
		localparam logic [3:0] OFS = 4'(c) * ump_pkg::CHAN_STRIDE;
		localparam logic [7:0] MASK0 = (c == 0) ? ump_pkg::MODE0_MASK_A
			: ump_pkg::MODE0_MASK_B;
		logic       cmd_ptr_one;
		logic       cmd_ptr_zero;
		logic [3:0] cmd_code;

		// One address per channel reaches all three mode registers.
		assign hit_mode[c] = addr_i == (ump_pkg::MODE_A_ADDR | OFS); // RULE2
		assign hit_csr[c]  = addr_i == (ump_pkg::CSR_A_ADDR | OFS); // RULE8
		assign hit_cmd[c]  = addr_i == (ump_pkg::CMD_A_ADDR | OFS);
		assign mode_access[c] = hit_mode[c] && (wr_i || rd_i);
		assign cmd_code = wdata_i[ump_pkg::CMD_LSB +: 4];
		assign cmd_ptr_one  = wr_i && hit_cmd[c] && (cmd_code == ump_pkg::CMD_PTR_ONE);
		assign cmd_ptr_zero = wr_i && hit_cmd[c] && (cmd_code == ump_pkg::CMD_PTR_ZERO);

		// Pointer steps zero, one, two and then stays; commands override.
		assign next_pointer[c] =
			cmd_ptr_zero ? ump_pkg::PTR_ZERO : // RULE3
			cmd_ptr_one ? ump_pkg::PTR_ONE : // RULE17
			!mode_access[c] ? pointer[c] :
			(pointer[c] == ump_pkg::PTR_ZERO) ? ump_pkg::PTR_ONE : // RULE4
			(pointer[c] == ump_pkg::PTR_ONE) ? ump_pkg::PTR_TWO : // RULE5
			ump_pkg::PTR_TWO; // RULE6

		// The reserved low bits of channel B mode zero read back as zero.
		assign mode_read[c] =
			(pointer[c] == ump_pkg::PTR_ZERO) ? (mode_zero[c] & MASK0) : // RULE7
			(pointer[c] == ump_pkg::PTR_ONE) ? mode_one[c] : mode_two[c];

		// Pointer register; reset lands on mode zero.
		always_ff @(posedge clock_i) begin
			if (!nrst_i) begin
				pointer[c] <= ump_pkg::PTR_ZERO; // RULE3
			end else begin
				pointer[c] <= next_pointer[c];
			end
		end

		// Mode register writes go to whichever register the pointer names.
		always_ff @(posedge clock_i) begin
			if (!nrst_i) begin
				mode_zero[c] <= ump_pkg::MODE_RESET;
				mode_one[c]  <= ump_pkg::MODE_RESET;
				mode_two[c]  <= ump_pkg::MODE_RESET;
			end else if (wr_i && hit_mode[c]) begin
				unique case (pointer[c])
					ump_pkg::PTR_ZERO: mode_zero[c] <= wdata_i & MASK0; // RULE7
					ump_pkg::PTR_ONE:  mode_one[c]  <= wdata_i;
					ump_pkg::PTR_TWO:  mode_two[c]  <= wdata_i;
					default:           mode_two[c]  <= wdata_i;
				endcase
			end
		end

		// Clock select is write-only; its codes drive the baud selection.
		always_ff @(posedge clock_i) begin
			if (!nrst_i) begin
				clock_select[c] <= ump_pkg::CSR_RESET;
			end else if (wr_i && hit_csr[c]) begin
				clock_select[c] <= wdata_i; // RULE8
			end
		end
	end

	// The aux control register is kept whole even though only bit 7 is used here.
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			aux_control_reg <= ump_pkg::AUX_RESET;
		end else if (wr_i && hit_aux) begin
			aux_control_reg <= wdata_i;
		end
	end

	// Read data; clock select and command registers are write-only and read zero.
	assign next_rdata =
		!rd_i ? 8'h00 :
		hit_mode[0] ? mode_read[0] :
		hit_mode[1] ? mode_read[1] :
		hit_aux ? aux_control_reg :
		hit_status ? {1'b0, pointer[1], 1'b0, pointer[0]} :
		8'h00;

	// Read data stands for exactly one cycle after the strobe.
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			rdata_o <= 8'h00;
		end else begin
			rdata_o <= next_rdata;
		end
	end

	// Phase accumulator makes an exact 3.6864 MHz tick from the 100 MHz clock.
	assign phase_sum = {1'b0, phase} + {1'b0, ump_pkg::NCO_STEP};
	assign ref_wrap  = phase_sum >= {1'b0, ump_pkg::NCO_MOD};

	// Jitter is one system clock per tick; the mean rate is exact.
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			phase    <= 20'h00000;
			ref_tick <= 1'b0;
		end else begin
			phase    <= ref_wrap ? 20'(phase_sum - {1'b0, ump_pkg::NCO_MOD})
				: phase_sum[19:0]; // RULE16
			ref_tick <= ref_wrap; // RULE16
		end
	end

	// External clock pins are synchronous; a rising edge counts as one clock.
	assign pin_three_edge = input_pin_three_i && !pin_three_q;
	assign pin_four_edge  = input_pin_four_i && !pin_four_q;

	// Previous pin levels for edge detection.
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			pin_three_q <= 1'b0;
			pin_four_q  <= 1'b0;
		end else begin
			pin_three_q <= input_pin_three_i;
			pin_four_q  <= input_pin_four_i;
		end
	end

	// Four clock paths: index 2*c is channel c receiver, 2*c+1 its transmitter.
	logic [3:0] path_sample;
	logic [3:0] path_bit;
	logic [3:0] path_x1;

	for (genvar p = 0; p < 4; p++) begin : g_path
		localparam int CH = p / 2;
		localparam bit IS_TX = (p % 2) == 1;
		logic [3:0]       code;
		logic [DIV_W-1:0] divisor;
		logic             gen_tick;
		logic             pin_edge;
		logic             sel_tick;
		logic             is_x1;
		logic [3:0]       sub;
		logic             next_bit;

		// Receiver code sits in the high nibble, transmitter in the low.
		assign code = IS_TX ? clock_select[CH][3:0] : clock_select[CH][7:4]; // RULE8
		assign divisor = DIV_W'(ump_pkg::ump_divisor(code, ext1, ext2, aux_set)); // RULE18
		// Receivers take pin four, transmitters pin three.
		assign pin_edge = IS_TX ? pin_three_edge : pin_four_edge; // RULE9 RULE10
		assign is_x1 = code == ump_pkg::SEL_PIN_X1; // RULE11 RULE12

		// Rate generator, one per path so that every path may differ.
		ump_rate_div #(
			.W(DIV_W)
		) u_div (
			.clock_i   (clock_i),
			.nrst_i    (nrst_i),
			.ref_tick_i(ref_tick),
			.divisor_i (divisor),
			.tick_o    (gen_tick)
		);

		// Source selection: timer, external pin, or the rate generator.
		assign sel_tick =
			(code == ump_pkg::SEL_TIMER) ? timer_tick_i : // RULE15
			((code == ump_pkg::SEL_PIN_X16) || is_x1) ? pin_edge : // RULE9 RULE10
			gen_tick; // RULE13 RULE14 RULE16

		// A 1x clock is itself the bit clock; a 16x clock is divided by sixteen.
		assign next_bit = is_x1 ? sel_tick // RULE11 RULE12
			: (sel_tick && (sub == 4'(ump_pkg::OVERSAMPLE - 1)));

		// Sample and bit ticks are registered so every output is a flop.
		always_ff @(posedge clock_i) begin
			if (!nrst_i) begin
				sub            <= 4'h0;
				path_sample[p] <= 1'b0;
				path_bit[p]    <= 1'b0;
				path_x1[p]     <= 1'b0;
			end else begin
				if (sel_tick && !is_x1) begin
					sub <= sub + 4'h1;
				end
				path_sample[p] <= sel_tick;
				path_bit[p]    <= next_bit;
				path_x1[p]     <= is_x1;
			end
		end
	end

	// Route the paths to the per-channel output ports.
	for (genvar c = 0; c < 2; c++) begin : g_out
		logic [3:0] stop_code;
		logic       five_bit;
		logic [5:0] next_stop;

		assign rx_sample_tick_o[c] = path_sample[2*c];
		assign rx_bit_tick_o[c]    = path_bit[2*c];
		assign rx_x1_o[c]          = path_x1[2*c];
		assign tx_sample_tick_o[c] = path_sample[2*c+1];
		assign tx_bit_tick_o[c]    = path_bit[2*c+1];
		assign tx_x1_o[c]          = path_x1[2*c+1];

		// Stop code in mode two low nibble; character length in mode one low bits.
		assign stop_code = mode_two[c][3:0];
		assign five_bit  = mode_one[c][1:0] == ump_pkg::CHAR_FIVE;
		// Codes step in sixteenths; the short half gains half a bit for five-bit data.
		assign next_stop =
			(stop_code == 4'hF) ? ump_pkg::STOP_TWO : // RULE1
			!stop_code[3] ? (ump_pkg::STOP_SHORT_BASE + {3'b000, stop_code[2:0]}
				+ (five_bit ? ump_pkg::STOP_FIVE_EXTRA : 6'h00)) : // RULE1
			(ump_pkg::STOP_LONG_BASE + {2'b00, stop_code}) - 6'h08 + 6'h08;

		// Registered stop length.
		always_ff @(posedge clock_i) begin
			if (!nrst_i) begin
				stop_len_o[c] <= ump_pkg::STOP_SHORT_BASE;
			end else begin
				stop_len_o[c] <= next_stop;
			end
		end
	end

endmodule

`default_nettype wire

// ---- dv/ump_top_asserts.sv ----
`default_nettype none

// Checks the register port and clock outputs from the top module's pins alone.
module ump_top_asserts (
	// Clock and reset.
	input  wire logic       clock_i,
	input  wire logic       nrst_i,
	// Register port.
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	input  wire logic [7:0] rdata_o,
	// Clock sources.
	input  wire logic       input_pin_four_i,
	input  wire logic       timer_tick_i,
	// Clock outputs.
	input  wire logic [1:0] rx_sample_tick_o,
	input  wire logic [1:0] rx_bit_tick_o,
	input  wire logic [1:0] tx_sample_tick_o,
	input  wire logic [1:0] tx_bit_tick_o,
	input  wire logic [1:0] tx_x1_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	logic [7:0] csr_a;
	logic [7:0] csr_b;
	logic [1:0] ptr_b;
	// Shadow decode; the pointer is mirrored so reads can be judged without the design.
	wire        mode_b_hit = (wr_i || rd_i) && (addr_i == 4'h8);
	wire        cmd_b_hit  = wr_i && (addr_i == 4'hA);
	wire  [7:0] next_csr_a = !nrst_i ? 8'h00 : (wr_i && addr_i == 4'h1) ? wdata_i : csr_a;
	wire  [7:0] next_csr_b = !nrst_i ? 8'h00 : (wr_i && addr_i == 4'h9) ? wdata_i : csr_b;
	wire  [1:0] next_ptr_b = !nrst_i ? 2'h0 :
		(cmd_b_hit && wdata_i[7:4] == 4'hB) ? 2'h0 :
		(cmd_b_hit && wdata_i[7:4] == 4'h1) ? 2'h1 :
		(mode_b_hit && ptr_b != 2'h2) ? ptr_b + 2'h1 : ptr_b;

	// Shadow registers follow every bus write.
	always_ff @(posedge clock_i) begin
		csr_a <= next_csr_a;
		csr_b <= next_csr_b;
		ptr_b <= next_ptr_b;
	end

	a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data not zero outside a read answer");
	a_wo_zero: assert property (rd_i && (addr_i[2:0] == 3'h1 || addr_i[2:0] == 3'h2) |=> rdata_o == 8'h00)
		else $error("write-only register returned data");
	a_status_ptr: assert property (rd_i && addr_i == 4'h5 |=> rdata_o[6:4] == (3'b001 << ptr_b))
		else $error("channel B pointer differs from expected");
	a_mode_zero_low: assert property (rd_i && addr_i == 4'h8 && ptr_b == 2'h0 |=> rdata_o[3:0] == 4'h0)
		else $error("reserved low bits of channel B mode zero not zero");
	a_pin_tick: assert property ($rose(input_pin_four_i) && csr_b[7:4] == 4'hE |-> ##[1:2] rx_sample_tick_o[1])
		else $error("pin four edge gave no receiver tick");
	a_timer_tick: assert property (timer_tick_i && csr_a[7:4] == 4'hD |=> rx_sample_tick_o[0])
		else $error("timer pulse gave no receiver tick");
	a_tx_x1_level: assert property (wr_i && addr_i == 4'h9 |-> ##2 (tx_x1_o[1] == (csr_b[3:0] == 4'hF)))
		else $error("transmitter 1x flag does not follow its code");
	a_bit_has_sample: assert property (rx_bit_tick_o[1] |-> rx_sample_tick_o[1])
		else $error("receiver bit tick without sample tick");
	a_x1_every_bit: assert property (tx_x1_o[1] && tx_sample_tick_o[1] |-> tx_bit_tick_o[1])
		else $error("1x transmitter clock missed a bit tick");
endmodule

bind ump_top ump_top_asserts chk (.clock_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
	.input_pin_four_i, .timer_tick_i, .rx_sample_tick_o, .rx_bit_tick_o, .tx_sample_tick_o,
	.tx_bit_tick_o, .tx_x1_o);

`default_nettype wire

// ---- dv/ump_host.sv ----
`default_nettype none

// Host processor model; strobes are one cycle and the slave never stalls.
module ump_host (
	// Clock.
	input  wire logic       clock_i,
	// Register port.
	output logic      [3:0] addr_o,
	output logic      [7:0] wdata_o,
	output logic            wr_o,
	output logic            rd_o,
	input  wire logic [7:0] rdata_i
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle bus at time zero.
	initial begin
		addr_o = 4'h0;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	// Released data is inverted so a stale byte can never pass for a fresh one.
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clock_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
	endtask

	// Read data stand only in the cycle after the strobe.
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clock_i);
		rd_o <= 1'b0;
		#1 d = rdata_i;
	endtask
endmodule

`default_nettype wire

// ---- dv/uart_mode_pointer_and_baud_select_bench.sv ----
`default_nettype none

`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
	$display("wrong value %s expected %0h seen %0h", n, e, g); end end

// Self-checking bench for pointer sequencing, stop length and clock selection.
module uart_mode_pointer_and_baud_select_bench;
	timeunit 1ns;
	timeprecision 1ns;

	logic            clock_i = 1'b0;
	logic            nrst_i = 1'b0;
	logic      [3:0] addr;
	logic      [7:0] wdata;
	logic            wr;
	logic            rd;
	logic      [7:0] rdata_o;
	logic            pin3 = 1'b0;
	logic            pin4 = 1'b0;
	logic            timer = 1'b0;
	logic      [1:0] rx_s, rx_b, rx_x1, tx_s, tx_b, tx_x1;
	logic [1:0][5:0] stop_len_o;
	logic      [7:0] sc[4];
	logic      [7:0] bc[4];
	int              failures = 0;
	int              comparisons = 0;

	ump_host host (.clock_i(clock_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
		.rdata_i(rdata_o));
	ump_top dut (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdata_o), .input_pin_three_i(pin3), .input_pin_four_i(pin4),
		.timer_tick_i(timer), .rx_sample_tick_o(rx_s), .rx_bit_tick_o(rx_b), .rx_x1_o(rx_x1),
		.tx_sample_tick_o(tx_s), .tx_bit_tick_o(tx_b), .tx_x1_o(tx_x1), .stop_len_o(stop_len_o));

	// Free-running 100 MHz clock.
	always #5 clock_i = ~clock_i;

	task automatic finish_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] d;
		host.rd_reg(a, d);
		`CHK("read data", e, d)
	endtask

	// One source pulse every five cycles; ticks of all four clocks are counted.
	task automatic pulse(input int sel, input int n);
		logic [3:0] st;
		logic [3:0] bt;
		for (int i = 0; i < 4; i++) begin
			sc[i] = 8'h00;
			bc[i] = 8'h00;
		end
		repeat (n + 1) begin
			@(posedge clock_i);
			timer <= (sel == 0) && (n > 0);
			pin3 <= (sel == 1) && (n > 0);
			pin4 <= (sel == 2) && (n > 0);
			n--;
			repeat (4) begin
				@(posedge clock_i);
				{timer, pin3, pin4} <= 3'h0;
				#1;
				// A concatenation cannot be indexed, so the four paths are gathered first.
				st = {tx_s, rx_s};
				bt = {tx_b, rx_b};
				for (int i = 0; i < 4; i++) begin
					sc[i] += {7'h00, st[i]};
					bc[i] += {7'h00, bt[i]};
				end
			end
		end
	endtask

	// The stop length is registered after the mode write, so let two edges pass first.
	task automatic settle();
		repeat (2) @(posedge clock_i);
		#1;
	endtask

	task automatic t_reset();
		`CHK("stop length", {6'h11, 6'h11}, stop_len_o)
		chk_rd(4'h5, 8'h11);
	endtask

	// Walks the shared address through zero, one and two, then both commands.
	task automatic t_pointer();
		host.wr_reg(4'h8, 8'hA5);
		host.wr_reg(4'h8, 8'h03);
		host.wr_reg(4'h8, 8'h0F);
		host.wr_reg(4'h8, 8'h07);
		chk_rd(4'h5, 8'h41);
		`CHK("stop length b", 6'h10, stop_len_o[1])
		host.wr_reg(4'hA, 8'hB0);
		chk_rd(4'h8, 8'hA0);
		chk_rd(4'h8, 8'h03);
		chk_rd(4'h8, 8'h07);
		chk_rd(4'h8, 8'h07);
		host.wr_reg(4'hA, 8'h10);
		chk_rd(4'h5, 8'h21);
		host.wr_reg(4'h8, 8'h00);
		settle();
		`CHK("stop five bit", 6'h18, stop_len_o[1])
		host.wr_reg(4'h8, 8'h0F);
		settle();
		`CHK("stop two", 6'h20, stop_len_o[1])
		chk_rd(4'h8, 8'h0F);
	endtask

	// Write-only and unmapped places read as zero.
	task automatic t_unmapped();
		host.wr_reg(4'h9, 8'h5A);
		chk_rd(4'h9, 8'h00);
		chk_rd(4'hA, 8'h00);
		chk_rd(4'h3, 8'h00);
	endtask

	task automatic t_sources();
		host.wr_reg(4'h1, 8'hDD);
		host.wr_reg(4'h9, 8'hEF);
		pulse(0, 16);
		`CHK("timer ticks", {sc[0], bc[0], sc[2], bc[2], sc[1], sc[3]}, 48'h100110010000)
		pulse(2, 16);
		`CHK("pin four ticks", {sc[1], bc[1], sc[3], rx_x1[1]}, 25'h0200200)
		pulse(1, 16);
		`CHK("pin three ticks", {sc[3], bc[3], sc[1], tx_x1[1]}, 25'h0202001)
	endtask

	// Code C per mode and aux bit, measured over a fixed window.
	task automatic t_rates();
		logic [7:0] m0[6] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h04, 8'h04};
		int         baud[6] = '{38400, 19200, 230400, 115200, 38400, 19200};
		int         e;
		logic [15:0] cnt;
		host.wr_reg(4'h1, 8'hCC);
		for (int r = 0; r < 6; r++) begin
			host.wr_reg(4'h2, 8'hB0);
			host.wr_reg(4'h0, m0[r]);
			host.wr_reg(4'h4, (r % 2) ? 8'h80 : 8'h00);
			repeat (500) @(posedge clock_i);
			cnt = 16'h0000;
			repeat (8138) @(posedge clock_i) #1 cnt += {15'h0000, tx_s[0]};
			// Every rate here is a multiple of 100; dividing first keeps the product in an int.
			e = (baud[r] / 100) * 16 * 8138 / 1000000;
			`CHK("rate in window", 1'b1, (cnt >= e - 1) && (cnt <= e + 1))
		end
	endtask

	// Main sequence; the watchdog cuts a hang short.
	initial begin
		repeat (5) @(posedge clock_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		t_reset();
		t_sources();
		t_pointer();
		t_unmapped();
		t_rates();
		finish_test();
	end

	initial begin
		#2000000;
		failures++;
		finish_test();
	end
endmodule

`default_nettype wire
